//--- rtl/agc_access_guard.sv
`timescale 1ns/1ps
// Operation
// [RL1] one 8-bit control register at f0078h, zero after reset
// [RL2] bits: detect enable, 0, ram guard hi/lo, 0, port, irq, chip-state guard
// [RL3] detection of invalid accesses only while detect enable is one; the code also detects while wdt_option_on is one and the bit reads zero
// [RL4] ram guard field: none, first 128, 256 or 512 bytes
// [RL5] port guard blocks port configuration writes, reads stay allowed
// [RL6] interrupt guard blocks interrupt register writes, reads stay allowed
// [RL7] interrupt guard covers request, mask, priority and edge select registers
// [RL8] chip-state guard blocks chip state control writes, reads stay allowed
// [RL9] chip-state guard covers clock, stabilisation, peripheral, voltage, parity registers
// [RL10] blocked writes leave contents unchanged and raise no flag or reset
// [RL11] a cleared guard applies at once to following writes
// [RL12] reserved bits 6 and 3 read zero, writes ignored
// [RL13] detect enable, once set, clears only by reset
// [RL14] detected invalid access raises internal reset and sets its source flag
// [RL15] watchdog option forces detection on regardless of detect enable
// [RL16] guarded ram reads normally, writes blocked silently
module agc_access_guard (
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    // axi4-lite slave
    input  wire logic [agc_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [agc_pkg::DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [agc_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [agc_pkg::DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // cpu memory write path
    input  wire logic                        mem_wr_req,
    input  wire agc_pkg::agc_target_t        mem_wr_target,
    input  wire logic [agc_pkg::OFS_W-1:0]   mem_wr_ram_ofs,
    output logic                             mem_wr_grant,
    // invalid access detection
    input  wire logic                        bad_access_seen,
    input  wire logic                        wdt_option_on,
    output logic                             detect_active,
    output logic                             internal_reset_req,
    output logic                             irq
);
    import agc_pkg::*;

    // ****************************************
    // register state
    // ****************************************
    logic                  bad_access_detect_enable;
    logic                  ram_guard_size_hi;
    logic                  ram_guard_size_lo;
    logic                  port_config_guard;
    logic                  irq_register_guard;
    logic                  chip_state_guard;
    logic                  bad_access_reset_flag;
    logic [EV_W-1:0]       irq_status;
    logic [EV_W-1:0]       irq_mask;

    logic [7:0]            access_guard_control;
    logic [7:0]            next_access_guard_control;
    logic                  detect_on;
    logic                  bad_hit;
    logic [EV_W-1:0]       ev_set;

    // ****************************************
    // axi write channel state
    // ****************************************
    logic                  aw_held;
    logic                  w_held;
    logic [ADDR_W-1:0]     aw_addr;
    logic [DATA_W-1:0]     w_data;
    logic [3:0]            w_strb;
    logic                  wr_fire;
    logic                  wr_hit;
    logic                  lane0;
    logic [DATA_W-1:0]     rd_word;
    logic                  rd_hit;

    agc_guard_if gif ();

    // ****************************************
    // control register view
    // ****************************************
    always_comb begin
        access_guard_control             = GUARD_CTRL_RESET; // RL12
        access_guard_control[DETECT_BIT] = bad_access_detect_enable; // RL2
        access_guard_control[RAM_HI_BIT] = ram_guard_size_hi;
        access_guard_control[RAM_LO_BIT] = ram_guard_size_lo;
        access_guard_control[PORT_BIT]   = port_config_guard;
        access_guard_control[IRQ_BIT]    = irq_register_guard;
        access_guard_control[CSC_BIT]    = chip_state_guard;
    end

    assign next_access_guard_control = w_data[7:0];

    // ****************************************
    // write address and data capture
    // ****************************************
    // address and data may come in either order; each is held until both are here
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign lane0   = w_strb[0];

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            aw_held       <= 1'b0;
            aw_addr       <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            w_held       <= 1'b0;
            w_data       <= '0;
            w_strb       <= '0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // ****************************************
    // write response
    // ****************************************
    always_comb begin
        unique case (aw_addr)
            GUARD_CTRL_ADDR,
            RESET_SRC_ADDR,
            IRQ_STATUS_ADDR,
            IRQ_MASK_ADDR: wr_hit = 1'b1;
            default:       wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************
    // guard control register
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ram_guard_size_hi  <= GUARD_CTRL_RESET[RAM_HI_BIT]; // RL1
            ram_guard_size_lo  <= GUARD_CTRL_RESET[RAM_LO_BIT];
            port_config_guard  <= GUARD_CTRL_RESET[PORT_BIT];
            irq_register_guard <= GUARD_CTRL_RESET[IRQ_BIT];
            chip_state_guard   <= GUARD_CTRL_RESET[CSC_BIT];
        end else if (wr_fire && lane0 && aw_addr == GUARD_CTRL_ADDR) begin
            // new guard value is used by the very next write on the cpu path
            ram_guard_size_hi  <= next_access_guard_control[RAM_HI_BIT]; // RL2
            ram_guard_size_lo  <= next_access_guard_control[RAM_LO_BIT];
            port_config_guard  <= next_access_guard_control[PORT_BIT];
            irq_register_guard <= next_access_guard_control[IRQ_BIT]; // RL11
            chip_state_guard   <= next_access_guard_control[CSC_BIT];
        end
    end

    // sticky: a write of zero cannot disarm detection
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bad_access_detect_enable <= GUARD_CTRL_RESET[DETECT_BIT]; // RL1
        end else if (wr_fire && lane0 && aw_addr == GUARD_CTRL_ADDR) begin
            bad_access_detect_enable <= bad_access_detect_enable
                                        | next_access_guard_control[DETECT_BIT]; // RL13
        end
    end

    // ****************************************
    // invalid access detection
    // ****************************************
    assign detect_on = bad_access_detect_enable || wdt_option_on; // RL3 RL15
    assign bad_hit   = detect_on && bad_access_seen; // RL3

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            internal_reset_req <= 1'b0;
            detect_active      <= 1'b0;
        end else begin
            internal_reset_req <= bad_hit; // RL14
            detect_active      <= detect_on;
        end
    end

    // flag survives the internal reset it causes; only sys_rst or a one clears it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bad_access_reset_flag <= 1'b0;
        end else if (bad_hit) begin
            bad_access_reset_flag <= 1'b1; // RL14
        end else if (wr_fire && lane0 && aw_addr == RESET_SRC_ADDR && w_data[RSRC_BAD_BIT]) begin
            bad_access_reset_flag <= 1'b0;
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    always_comb begin
        ev_set                  = '0;
        ev_set[EV_BAD_ACCESS]   = bad_hit;
        ev_set[EV_DETECT_ARMED] = detect_on && !detect_active;
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq_status <= EV_RESET;
        end else if (wr_fire && lane0 && aw_addr == IRQ_STATUS_ADDR) begin
            irq_status <= (irq_status & ~w_data[EV_W-1:0]) | ev_set;
        end else begin
            irq_status <= irq_status | ev_set;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq_mask <= EV_RESET;
        end else if (wr_fire && lane0 && aw_addr == IRQ_MASK_ADDR) begin
            irq_mask <= w_data[EV_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr)
            GUARD_CTRL_ADDR: rd_word[7:0] = access_guard_control; // RL12
            RESET_SRC_ADDR:  rd_word[RSRC_BAD_BIT] = bad_access_reset_flag;
            IRQ_STATUS_ADDR: rd_word[EV_W-1:0] = irq_status;
            IRQ_MASK_ADDR:   rd_word[EV_W-1:0] = irq_mask;
            default:         rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // cpu write filter
    // ****************************************
    // reads never pass through here, so guarded targets stay readable
    assign gif.ram_guard  = {ram_guard_size_hi, ram_guard_size_lo}; // RL4
    assign gif.port_guard = port_config_guard; // RL5
    assign gif.irq_guard  = irq_register_guard; // RL6
    assign gif.csc_guard  = chip_state_guard; // RL8
    assign gif.wr_req     = mem_wr_req;
    assign gif.wr_target  = mem_wr_target;
    assign gif.wr_ram_ofs = mem_wr_ram_ofs;
    assign mem_wr_grant   = gif.wr_grant;

    agc_write_filter u_filter (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .gif     (gif.flt)
    );

endmodule

//--- rtl/agc_pkg.sv
package agc_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int OFS_W  = 16;

    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [ADDR_W-1:0] GUARD_CTRL_ADDR = 20'hf0078;
    localparam logic [ADDR_W-1:0] RESET_SRC_ADDR  = 20'hf007c;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 20'hf0080;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR   = 20'hf0084;

    // ****************************************
    // guard control fields and reset values
    // ****************************************
    localparam int          DETECT_BIT       = 7;
    localparam int          RAM_HI_BIT       = 5;
    localparam int          RAM_LO_BIT       = 4;
    localparam int          PORT_BIT         = 2;
    localparam int          IRQ_BIT          = 1;
    localparam int          CSC_BIT          = 0;
    localparam logic [7:0]  GUARD_CTRL_RESET = 8'h00;
    localparam logic [1:0]  RAM_GUARD_RESET  = 2'h0;
    localparam logic [15:0] RAM_GUARD_128    = 16'h0080;
    localparam logic [15:0] RAM_GUARD_256    = 16'h0100;
    localparam logic [15:0] RAM_GUARD_512    = 16'h0200;

    // ****************************************
    // status, mask and reset source fields
    // ****************************************
    localparam int         EV_W            = 2;
    localparam int         EV_BAD_ACCESS   = 0;
    localparam int         EV_DETECT_ARMED = 1;
    localparam logic [1:0] EV_RESET        = 2'h0;
    localparam int         RSRC_BAD_BIT    = 0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // classes of write target, from the address decoder
    // ****************************************
    typedef enum logic [4:0] {
        AGC_TGT_OTHER,
        AGC_TGT_PORT_CFG,
        AGC_TGT_IRQ_REQ,
        AGC_TGT_IRQ_MASK,
        AGC_TGT_IRQ_PRIO,
        AGC_TGT_IRQ_RISE,
        AGC_TGT_IRQ_FALL,
        AGC_TGT_CSC_CLK_MODE,
        AGC_TGT_CSC_CLK_STATUS,
        AGC_TGT_CSC_OSC_STAB,
        AGC_TGT_CSC_SYS_CLK,
        AGC_TGT_CSC_PERIPH,
        AGC_TGT_CSC_SUBCLK,
        AGC_TGT_CSC_VDET_MODE,
        AGC_TGT_CSC_VDET_LEVEL,
        AGC_TGT_CSC_RAM_PARITY,
        AGC_TGT_RAM
    } agc_target_t;

endpackage

//--- rtl/agc_guard_if.sv
`timescale 1ns/1ps
interface agc_guard_if;
    import agc_pkg::*;
    logic [1:0]       ram_guard;
    logic             port_guard;
    logic             irq_guard;
    logic             csc_guard;
    logic             wr_req;
    agc_target_t      wr_target;
    logic [OFS_W-1:0] wr_ram_ofs;
    logic             wr_grant;

    modport ctl (output ram_guard, port_guard, irq_guard, csc_guard,
                 output wr_req, wr_target, wr_ram_ofs, input wr_grant);
    modport flt (input ram_guard, port_guard, irq_guard, csc_guard,
                 input wr_req, wr_target, wr_ram_ofs, output wr_grant);
endinterface

//--- rtl/agc_write_filter.sv
`timescale 1ns/1ps
module agc_write_filter (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    agc_guard_if.flt  gif
);
    import agc_pkg::*;

    logic [OFS_W-1:0] ram_limit;
    logic             blocked;

    // ****************************************
    // guarded region size
    // ****************************************
    always_comb begin
        unique case (gif.ram_guard) // RL4
            2'h0: ram_limit = '0;
            2'h1: ram_limit = RAM_GUARD_128;
            2'h2: ram_limit = RAM_GUARD_256;
            2'h3: ram_limit = RAM_GUARD_512;
        endcase
    end

    // ****************************************
    // target classification
    // ****************************************
    always_comb begin
        unique case (gif.wr_target)
            AGC_TGT_PORT_CFG:       blocked = gif.port_guard; // RL5
            AGC_TGT_IRQ_REQ,
            AGC_TGT_IRQ_MASK,
            AGC_TGT_IRQ_PRIO,
            AGC_TGT_IRQ_RISE,
            AGC_TGT_IRQ_FALL:       blocked = gif.irq_guard; // RL6 RL7
            AGC_TGT_CSC_CLK_MODE,
            AGC_TGT_CSC_CLK_STATUS,
            AGC_TGT_CSC_OSC_STAB,
            AGC_TGT_CSC_SYS_CLK,
            AGC_TGT_CSC_PERIPH,
            AGC_TGT_CSC_SUBCLK,
            AGC_TGT_CSC_VDET_MODE,
            AGC_TGT_CSC_VDET_LEVEL,
            AGC_TGT_CSC_RAM_PARITY: blocked = gif.csc_guard; // RL8 RL9
            AGC_TGT_RAM:            blocked = gif.wr_ram_ofs < ram_limit; // RL16
            default:                blocked = 1'b0;
        endcase
    end

    // ****************************************
    // grant, one cycle after the request
    // ****************************************
    // a refused write just loses its strobe; no flag on purpose
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gif.wr_grant <= 1'b0;
        end else begin
            gif.wr_grant <= gif.wr_req && !blocked; // RL10
        end
    end

endmodule

//--- test/agc_access_guard_sva.sv
`timescale 1ns/1ps
module agc_access_guard_sva (
    input wire logic                   sys_clk,
    input wire logic                   sys_rst,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire logic                   mem_wr_req,
    input wire agc_pkg::agc_target_t   mem_wr_target,
    input wire logic [15:0]            mem_wr_ram_ofs,
    input wire logic                   mem_wr_grant,
    input wire logic                   bad_access_seen,
    input wire logic                   wdt_option_on,
    input wire logic                   detect_active,
    input wire logic                   internal_reset_req
);
    import agc_pkg::*;

    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_reset_one_cycle: assert property (internal_reset_req |=> !internal_reset_req)
        else $error("reset request longer than one cycle");
    a_reset_has_cause: assert property (internal_reset_req |-> $past(bad_access_seen))
        else $error("reset request without a bad access");
    // bvalid excluded: detect_active trails a control write by one cycle
    a_no_detect_off: assert property (bad_access_seen && !detect_active && !wdt_option_on && !s_axi_bvalid
        |=> !internal_reset_req)
        else $error("reset request while detection is off");
    a_detect_resets: assert property (bad_access_seen && detect_active && $stable(wdt_option_on)
        |=> internal_reset_req)
        else $error("armed detection gave no reset request");
    a_grant_cause: assert property (mem_wr_grant |-> $past(mem_wr_req))
        else $error("grant without a write request");
    a_other_granted: assert property (mem_wr_req && mem_wr_target == AGC_TGT_OTHER |=> mem_wr_grant)
        else $error("unguarded target refused");
    a_ram_beyond: assert property (mem_wr_req && mem_wr_target == AGC_TGT_RAM
        && mem_wr_ram_ofs >= 16'h0200 |=> mem_wr_grant)
        else $error("ram write above largest guard refused");
    a_wdt_forces: assert property (wdt_option_on |=> detect_active)
        else $error("watchdog option did not arm detection");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
endmodule

//--- test/agc_access_guard_bench.sv
`timescale 1ns/1ps
module agc_access_guard_bench;
    import agc_pkg::*;

    logic                sys_clk;
    logic                sys_rst;
    logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0]   s_axi_wdata, s_axi_rdata;
    logic [3:0]          s_axi_wstrb;
    logic [1:0]          s_axi_bresp, s_axi_rresp;
    logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic                mem_wr_req, mem_wr_grant, bad_access_seen, wdt_option_on;
    logic                detect_active, internal_reset_req, irq;
    agc_target_t         mem_wr_target;
    logic [OFS_W-1:0]    mem_wr_ram_ofs;
    int                  error_cnt = 0;
    int                  checked = 0;

    agc_access_guard dut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_wr_req,
        .mem_wr_target, .mem_wr_ram_ofs, .mem_wr_grant, .bad_access_seen, .wdt_option_on, .detect_active,
        .internal_reset_req, .irq);

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // bready stays high once raised; only the watchdog ends a hang
    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(s_axi_bresp, er, "bresp");
    endtask

    // rready raised late on purpose: read data must stand meanwhile
    task automatic axi_rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge sys_clk);
        chk(s_axi_rdata, ed, "rdata");
        chk(s_axi_rresp, er, "rresp");
        s_axi_rready <= 1'b0;
    endtask

    task automatic mem_try(input agc_target_t t, input logic [OFS_W-1:0] o, input logic eg);
        mem_wr_req <= 1'b1;
        mem_wr_target <= t;
        mem_wr_ram_ofs <= o;
        @(posedge sys_clk);
        mem_wr_req <= 1'b0;
        @(posedge sys_clk);
        chk(mem_wr_grant, eg, "grant");
    endtask

    task automatic pulse_bad(input logic e);
        bad_access_seen <= 1'b1;
        @(posedge sys_clk);
        bad_access_seen <= 1'b0;
        @(posedge sys_clk);
        chk(internal_reset_req, e, "reset req");
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reg();
        axi_rd(GUARD_CTRL_ADDR, 32'h0, RESP_OKAY);
        axi_wr(GUARD_CTRL_ADDR, 32'h7f, RESP_OKAY);
        axi_rd(GUARD_CTRL_ADDR, 32'h37, RESP_OKAY);
        axi_wr(GUARD_CTRL_ADDR, 32'h0, RESP_OKAY);
        axi_rd(GUARD_CTRL_ADDR, 32'h0, RESP_OKAY);
        axi_wr(20'hf0090, 32'h1, RESP_SLVERR);
        axi_rd(20'hf0090, 32'h0, RESP_SLVERR);
        $display("test reg done");
    endtask

    task automatic t_guard();
        logic [7:0]     c;
        logic           g;
        agc_target_t    e;
        logic [15:0]    lim;
        for (int k = 0; k < 4; k++) begin
            c = (k == 3) ? 8'h00 : 8'h01 << k;
            axi_wr(GUARD_CTRL_ADDR, {24'h0, c}, RESP_OKAY);
            for (int t = 0; t < 16; t++) begin
                e = agc_target_t'(5'(t));
                g = (e == AGC_TGT_PORT_CFG && c[PORT_BIT])
                    || (e inside {[AGC_TGT_IRQ_REQ:AGC_TGT_IRQ_FALL]} && c[IRQ_BIT])
                    || (e inside {[AGC_TGT_CSC_CLK_MODE:AGC_TGT_CSC_RAM_PARITY]} && c[CSC_BIT]);
                mem_try(e, 16'h0, !g);
            end
        end
        for (int s = 0; s < 4; s++) begin
            axi_wr(GUARD_CTRL_ADDR, 32'(s) << RAM_LO_BIT, RESP_OKAY);
            lim = (s == 0) ? 16'h0 : 16'h0040 << s;
            if (s > 0) mem_try(AGC_TGT_RAM, lim - 16'h1, 1'b0);
            mem_try(AGC_TGT_RAM, lim, 1'b1);
        end
        axi_wr(GUARD_CTRL_ADDR, 32'h0, RESP_OKAY);
        axi_rd(IRQ_STATUS_ADDR, 32'h0, RESP_OKAY);
        chk(irq, 1'b0, "irq after blocked");
        $display("test guard done");
    endtask

    task automatic t_detect();
        pulse_bad(1'b0);
        axi_rd(RESET_SRC_ADDR, 32'h0, RESP_OKAY);
        axi_wr(IRQ_MASK_ADDR, 32'h3, RESP_OKAY);
        wdt_option_on <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(detect_active, 1'b1, "wdt arm");
        pulse_bad(1'b1);
        axi_rd(RESET_SRC_ADDR, 32'h1, RESP_OKAY);
        axi_rd(IRQ_STATUS_ADDR, 32'h3, RESP_OKAY);
        chk(irq, 1'b1, "irq raised");
        wdt_option_on <= 1'b0;
        axi_wr(IRQ_STATUS_ADDR, 32'h3, RESP_OKAY);
        axi_wr(RESET_SRC_ADDR, 32'h1, RESP_OKAY);
        axi_rd(RESET_SRC_ADDR, 32'h0, RESP_OKAY);
        chk(irq, 1'b0, "irq cleared");
        chk(detect_active, 1'b0, "disarmed");
        axi_wr(IRQ_MASK_ADDR, 32'h1, RESP_OKAY);
        axi_wr(GUARD_CTRL_ADDR, 32'h80, RESP_OKAY);
        axi_wr(GUARD_CTRL_ADDR, 32'h0, RESP_OKAY);
        axi_rd(GUARD_CTRL_ADDR, 32'h80, RESP_OKAY);
        chk(detect_active, 1'b1, "sticky arm");
        chk(irq, 1'b0, "masked event");
        axi_rd(IRQ_STATUS_ADDR, 32'h2, RESP_OKAY);
        pulse_bad(1'b1);
        $display("test detect done");
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, mem_wr_ram_ofs} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {mem_wr_req, bad_access_seen, wdt_option_on} = '0;
        s_axi_wstrb = 4'hf;
        mem_wr_target = AGC_TGT_OTHER;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reg();
        t_guard();
        t_detect();
        stop_test();
    end

    // the whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test();
    end
endmodule

bind agc_access_guard agc_access_guard_sva u_sva (.sys_clk, .sys_rst, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .mem_wr_req, .mem_wr_target, .mem_wr_ram_ofs,
    .mem_wr_grant, .bad_access_seen, .wdt_option_on, .detect_active, .internal_reset_req);
